// *** include/efc_map.vh ***
// Register map, field layout, codes and timing constants for the encoder
// feedback configuration block. Assumes a 40 MHz aclk.
`ifndef EFC_MAP_VH
`define EFC_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define EFC_OFS_CFG      5'h00
`define EFC_OFS_LINES    5'h04
`define EFC_OFS_ABS      5'h08
`define EFC_OFS_BAUD     5'h0C
`define EFC_OFS_STAT     5'h10
`define EFC_OFS_MASK     5'h14
`define EFC_OFS_INFO     5'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define EFC_CFG_TYPE     3:0
`define EFC_CFG_SUPPLY   5:4
`define EFC_CFG_TERM     9:8
`define EFC_CFG_ERR      13:12
`define EFC_CFG_AUTO     16
`define EFC_ABS_TURNS    4:0
`define EFC_ABS_RES      13:8
`define EFC_ST_WIRE      0
`define EFC_ST_PHASE     1
`define EFC_ST_AUTO      2

// ****************************************************************
// Reset values
// ****************************************************************
`define EFC_RST_TYPE     4'h0
`define EFC_RST_SUPPLY   2'h0
`define EFC_RST_TERM     2'h1
`define EFC_RST_ERR      2'h0
`define EFC_RST_LINES    16'h0400
`define EFC_RST_BAUD     12'h12C

// ****************************************************************
// Encoder type codes
// ****************************************************************
`define EFC_T_FREQ_DIR_PLAIN       4'h1
`define EFC_T_FWD_REV_PLAIN        4'h2
`define EFC_T_FREQ_DIR_COMMUTATED  4'h4
`define EFC_T_FWD_REV_COMMUTATED   4'h5
`define EFC_T_SINCOS_SERIAL_A      4'h7
`define EFC_T_SERIAL_ONLY_B        4'h8
`define EFC_T_SINCOS_SERIAL_B      4'h9

// ****************************************************************
// Baud codes and link rates in kHz
// ****************************************************************
`define EFC_CLK_KHZ      40000
`define EFC_B100         12'h064
`define EFC_B200         12'h0C8
`define EFC_B300         12'h12C
`define EFC_B500         12'h1F4
`define EFC_B1000        12'h3E8
`define EFC_B1500        12'h5DC
`define EFC_B2000        12'h7D0
`define EFC_RATE_100K    100
`define EFC_RATE_200K    200
`define EFC_RATE_300K    300
`define EFC_RATE_500K    500
`define EFC_RATE_1M      1000
`define EFC_RATE_1M5     1500
`define EFC_RATE_2M      2000
// Bit periods in aclk cycles, rounded down
`define EFC_DIV_100K     16'h0190
`define EFC_DIV_200K     16'h00C8
`define EFC_DIV_300K     16'h0085
`define EFC_DIV_500K     16'h0050
`define EFC_DIV_1M       16'h0028
`define EFC_DIV_1M5      16'h001A
`define EFC_DIV_2M       16'h0014

// ****************************************************************
// Bus answers
// ****************************************************************
`define EFC_RESP_OKAY    2'h0
`define EFC_RESP_SLVERR  2'h2

`endif

// *** verification/efc_checker.sv ***
// Port-level assertions for the encoder feedback configuration block.
// Assumes it is bound into efc_top and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module efc_checker (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   // Encoder side
   input wire logic [2:0]  supply_sel,
   input wire logic        term_pulse_en,
   input wire logic        term_marker_en,
   input wire logic        cfg_req,
   input wire logic        cfg_valid,
   input wire logic [15:0] baud_div,
   input wire logic        baud_ok
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_supply_onehot: assert property ($onehot(supply_sel))
      else $error("supply select not one-hot");
   a_term_order: assert property (term_marker_en |-> term_pulse_en)
      else $error("marker terminator without pulse terminators");
   a_baud_rate: assert property (baud_ok |-> baud_div inside {16'h0190, 16'h00C8, 16'h0085, 16'h0050,
      16'h0028, 16'h001A, 16'h0014})
      else $error("baud divider not a link rate");
   a_baud_off: assert property (!baud_ok |-> baud_div == 16'h0000)
      else $error("baud divider set while invalid");
   a_cfg_hold: assert property (cfg_req && !cfg_valid |=> cfg_req)
      else $error("config request dropped early");
   a_cfg_done: assert property (cfg_req && cfg_valid |=> !cfg_req)
      else $error("config request held after answer");
   a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write response late");
   a_write_busy: assert property (bvalid |-> !awready && !wready)
      else $error("write accepted while response pending");
   a_resp_stable: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response not held");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   a_read_stable: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data not held");
endmodule // efc_checker

bind efc_top efc_checker u_efc_checker (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
   .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .supply_sel, .term_pulse_en, .term_marker_en,
   .cfg_req, .cfg_valid, .baud_div, .baud_ok);
`default_nettype wire

// *** verification/efc_encoder_model.sv ***
// Encoder side of the configuration exchange on the serial link.
// Assumes the testbench sets the answer delay and the values returned.
`timescale 1ns/100ps
`default_nettype none
module efc_encoder_model (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Answer set-up
   input  wire logic [7:0]  delay,
   input  wire logic [4:0]  turns,
   input  wire logic [5:0]  res,
   input  wire logic [15:0] lines,
   // Link exchange
   input  wire logic        cfg_req,
   output var  logic        cfg_valid,
   output wire logic [4:0]  cfg_turns,
   output wire logic [5:0]  cfg_res,
   output wire logic [15:0] cfg_lines
);
   logic [7:0] cnt_q;
   // Answer for one cycle after the chosen delay
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q     <= 8'h00;
         cfg_valid <= 1'b0;
      end else if (cfg_req && !cfg_valid) begin
         cnt_q     <= cnt_q + 8'h01;
         cfg_valid <= (cnt_q == delay);
      end else begin
         cnt_q     <= 8'h00;
         cfg_valid <= 1'b0;
      end
   end
   // Data lines show the inverse outside the answer cycle
   assign {cfg_turns, cfg_res, cfg_lines} = cfg_valid ? {turns, res, lines} : ~{turns, res, lines};
endmodule // efc_encoder_model
`default_nettype wire

// *** verification/tb_encoder_feedback_config.sv ***
// Self-checking testbench for efc_top with the encoder model.
// Assumes a 40 MHz aclk and the register map of efc_map.vh.
`timescale 1ns/100ps
`default_nettype none
`include "efc_map.vh"
module tb_encoder_feedback_config;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq, tpe, tme, creq, cval, bok;
   logic        wbp, wbm, wbs, phe;
   logic [4:0]  awaddr, araddr, cturn, p_turns;
   logic [31:0] wdata, rdata, v, ab;
   logic [3:0]  wstrb, t, d;
   logic [1:0]  bresp, rresp, r, tm, l, m, s;
   logic [2:0]  supply_sel;
   logic [5:0]  cres, p_res;
   logic [15:0] clines, bdiv, p_lines, ln, e;
   logic [11:0] b;
   logic [7:0]  p_delay;
   int          n_errors, samples_checked, i, j, k;
   logic [3:0]  types [7] = '{1, 2, 4, 5, 7, 8, 9}; // Plain pulse types assume vector use
   logic [11:0] bauds [7] = '{100, 200, 300, 500, 1000, 1500, 2000};

   efc_top u_efc_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq, .supply_sel,
      .term_pulse_en(tpe), .term_marker_en(tme), .wire_break_pulse(wbp), .wire_break_marker(wbm),
      .wire_break_sincos(wbs), .phase_err(phe), .cfg_req(creq), .cfg_valid(cval), .cfg_turns(cturn),
      .cfg_res(cres), .cfg_lines(clines), .baud_div(bdiv), .baud_ok(bok));
   efc_encoder_model u_efc_encoder_model (.aclk, .aresetn, .delay(p_delay), .turns(p_turns), .res(p_res),
      .lines(p_lines), .cfg_req(creq), .cfg_valid(cval), .cfg_turns(cturn), .cfg_res(cres), .cfg_lines(clines));

   initial aclk = 1'b0;
   always #12.5 aclk = ~aclk;

   task automatic final_report;
      if (n_errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic hang;
      n_errors++;
      final_report();
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
         n_errors++;
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] dat, output logic [1:0] rs);
      bit dn;
      dn = 0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= dat;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 64 && !dn; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            rs = bresp;
            bready <= 1'b0;
            dn = 1;
         end
      end
      if (!dn) hang();
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] dat, output logic [1:0] rs);
      bit dn;
      dn = 0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 64 && !dn; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            dat = rdata;
            rs = rresp;
            rready <= 1'b0;
            dn = 1;
         end
      end
      if (!dn) hang();
   endtask

   function automatic [15:0] exp_div(input logic [3:0] ty, input logic [11:0] bc);
      if ((ty == 8 || ty == 9) && bc inside {100, 200, 300, 500, 1000, 1500, 2000})
         return `EFC_CLK_KHZ / bc;
      return 16'h0000;
   endfunction
   function automatic [31:0] exp_info(input logic [3:0] ty, input logic [11:0] bc);
      return {24'h0, exp_div(ty, bc) != 0, 2'h0, ty == 8 || ty == 9, ty == 7 || ty == 9, ty == 4 || ty == 5,
              ty inside {1, 2, 4, 5}, 1'b0};
   endfunction
   function automatic [1:0] exp_stat(input logic [3:0] ty, input logic [1:0] lv, input logic [1:0] te,
                                     input logic [3:0] dt);
      logic p, c, sc;
      p  = ty inside {1, 2, 4, 5};
      c  = ty == 4 || ty == 5;
      sc = ty == 7 || ty == 9;
      return {lv[1] & (c | sc) & dt[3], lv[0] & ((p & ((dt[0] & te != 0) | (dt[1] & te == 2))) | (sc & dt[2]))};
   endfunction

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, wbp, wbm, wbs, phe} = 10'h000;
      {awaddr, araddr, wdata, wstrb, p_delay, p_turns, p_res, p_lines} = {42'h0, 4'hF, 35'h0};
      n_errors = 0;
      samples_checked = 0;
      void'($urandom(32'h7bbbd0fa));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`EFC_OFS_CFG, v, r);
      chk(v, 32'h00000100);
      rd(`EFC_OFS_BAUD, v, r);
      chk(v, 32'h0000012C);
      chk(32'({tme, tpe, supply_sel}), 32'h09);
      for (i = 0; i < 12; i++) begin
         s = 2'(i % 4);
         tm = (s == 0) ? 2'(i / 4) : 2'h0;
         wr(`EFC_OFS_CFG, {22'h0, tm, 2'h0, s, 4'h0}, r);
         repeat (2) @(posedge aclk);
         chk(32'(supply_sel), s == 1 ? 32'h2 : s == 2 ? 32'h4 : 32'h1);
         chk(32'({tme, tpe}), tm == 2 ? 32'h3 : tm == 1 ? 32'h1 : 32'h0);
      end
      for (i = 0; i < 7; i++)
         for (j = 0; j < 8; j++) begin
            b = (j == 7) ? 12'($urandom) : bauds[j];
            e = exp_div(types[i], b);
            wr(`EFC_OFS_BAUD, 32'(b), r);
            wr(`EFC_OFS_CFG, 32'(types[i]), r);
            repeat (2) @(posedge aclk);
            rd(`EFC_OFS_INFO, v, r);
            chk(v & 32'h0000009E, exp_info(types[i], b));
            chk(32'({bok, bdiv}), 32'({e != 0, e}));
         end
      for (k = 0; k < 60; k++) begin
         t = types[$urandom_range(0, 6)];
         {l, m, d} = 8'($urandom);
         tm = 2'($urandom_range(0, 2));
         wr(`EFC_OFS_MASK, 32'(m), r);
         wr(`EFC_OFS_CFG, {18'h0, l, 2'h0, tm, 4'h0, t}, r);
         rd(`EFC_OFS_STAT, v, r);
         {phe, wbs, wbm, wbp} <= d;
         @(posedge aclk);
         {phe, wbs, wbm, wbp} <= 4'h0;
         repeat (2) @(posedge aclk);
         chk(32'(irq), 32'(|(exp_stat(t, l, tm, d) & m)));
         rd(`EFC_OFS_STAT, v, r);
         chk(v, 32'(exp_stat(t, l, tm, d)));
      end
      rd(`EFC_OFS_STAT, v, r);
      chk(v, 32'h0);
      ln = 16'($urandom);
      ab = $urandom & 32'h00003F1F;
      wr(`EFC_OFS_LINES, 32'(ln), r);
      wr(`EFC_OFS_ABS, ab, r);
      rd(`EFC_OFS_LINES, v, r);
      chk(v, 32'(ln));
      rd(`EFC_OFS_ABS, v, r);
      chk(v, ab);
      for (i = 0; i < 2; i++) begin
         t = i ? 4'h7 : 4'h8;
         {p_turns, p_res, p_lines} <= 27'($urandom);
         p_delay <= i ? 8'h09 : 8'h00;
         wr(`EFC_OFS_CFG, 32'(t), r);
         wr(`EFC_OFS_CFG, 32'(t) | 32'h00010000, r);
         for (j = 0; j < 64 && creq; j++) @(posedge aclk);
         if (creq) hang();
         repeat (3) @(posedge aclk);
         rd(`EFC_OFS_ABS, v, r);
         chk(v, {18'h0, p_res, 3'h0, p_turns});
         rd(`EFC_OFS_LINES, v, r);
         chk(v, 32'(i ? p_lines : ln));
         rd(`EFC_OFS_STAT, v, r);
         chk(v, 32'h4);
         rd(`EFC_OFS_CFG, v, r);
         chk(v, 32'(t));
      end
      rd(5'h1C, v, r);
      chk({r, v[29:0]}, {`EFC_RESP_SLVERR, 30'h0});
      wr(`EFC_OFS_INFO, 32'hFFFFFFFF, r);
      chk(32'(r), 32'(`EFC_RESP_SLVERR));
      final_report();
   end
endmodule // tb_encoder_feedback_config
`default_nettype wire

// *** verilog/efc_top.v ***
// Encoder feedback configuration: AXI4-Lite registers, type decode, supply and
// termination drive, error checks, auto-configuration over the encoder link.
// Assumes one 40 MHz clock and encoder fault detectors synchronous to it.
//
// How it works
// - Types 1,2 pulse styles plain; 4,5 same styles with commutation inputs.
// - Supply code 0,1,2 drives 5 V, 8 V, 15 V encoder supply select.
// - Termination 0 none, 1 pulse inputs, 2 pulse and marker inputs.
// - Pulse types: level bit 0 wire break checks, bit 1 phase checks.
// - Phase checks run only for commutated pulse types among pulse types.
// - Pulse wire break is reported for termination 1,2,3; marker wire break only for termination 2.
// - Types 7,8,9 decode sincos serial a, serial only b, sincos serial b.
// - Auto-configure reads turns and resolution; lines only for sincos types.
// - Software may write turns, lines and resolution directly.
// - Serial b types decode baud codes 100..2000 into link rates.
// - Sincos types: level bit 0 sin/cos wire break, bit 1 phase checks.
`timescale 1ns/100ps
`default_nettype none
`include "efc_map.vh"

module efc_top (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address and data
   input  wire [4:0]  awaddr,
   input  wire        awvalid,
   output reg         awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output reg         wready,
   // AXI4-Lite write response
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   // AXI4-Lite read
   input  wire [4:0]  araddr,
   input  wire        arvalid,
   output reg         arready,
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   // Interrupt
   output reg         irq,
   // Encoder supply and termination
   output reg  [2:0]  supply_sel,
   output reg         term_pulse_en,
   output reg         term_marker_en,
   // Detectors from the input stage
   input  wire        wire_break_pulse,
   input  wire        wire_break_marker,
   input  wire        wire_break_sincos,
   input  wire        phase_err,
   // Encoder serial link configuration exchange
   output reg         cfg_req,
   input  wire        cfg_valid,
   input  wire [4:0]  cfg_turns,
   input  wire [5:0]  cfg_res,
   input  wire [15:0] cfg_lines,
   output reg  [15:0] baud_div,
   output reg         baud_ok
);

   localparam [2:0] ST_IDLE = 3'h1, ST_REQ = 3'h2, ST_DONE = 3'h4;

   reg  [3:0]  type_q, wstrb_q;
   reg  [1:0]  supply_q, term_q, err_q;
   reg         auto_q, aw_have_q, w_have_q, rd_hit, div_ok_d;
   reg  [15:0] lines_q, div_d;
   reg  [4:0]  turns_q, awaddr_q;
   reg  [5:0]  res_q;
   reg  [11:0] baud_q;
   reg  [2:0]  stat_q, mask_q, st_q, stat_d;
   reg  [31:0] wdata_q, old_word, new_word, rd_word;
   wire [31:0] lane_mask;
   wire        do_write, rd_take, auto_start, ev_wire, ev_phase, ev_auto;
   wire        is_pulse, is_comm, is_sincos, is_serial_b, is_serial, wire_chk, phase_chk;
   // ****************************************************************
   // Type decode
   // ****************************************************************
   assign is_pulse    = (type_q == `EFC_T_FREQ_DIR_PLAIN) || (type_q == `EFC_T_FWD_REV_PLAIN) ||
                        is_comm;
   assign is_comm     = (type_q == `EFC_T_FREQ_DIR_COMMUTATED) ||
                        (type_q == `EFC_T_FWD_REV_COMMUTATED);
   assign is_sincos   = (type_q == `EFC_T_SINCOS_SERIAL_A) ||
                        (type_q == `EFC_T_SINCOS_SERIAL_B);
   assign is_serial_b = (type_q == `EFC_T_SERIAL_ONLY_B) ||
                        (type_q == `EFC_T_SINCOS_SERIAL_B);
   assign is_serial   = is_sincos || is_serial_b;
   // ****************************************************************
   // Error checks
   // ****************************************************************
   assign wire_chk  = err_q[0] && (is_pulse || is_sincos);
   assign phase_chk = err_q[1] && (is_comm || is_sincos);
   assign ev_wire   = wire_chk && ((is_pulse && ((wire_break_pulse && term_q != 2'h0) ||
                      (wire_break_marker && term_q == 2'h2))) ||
                      (is_sincos && wire_break_sincos));
   assign ev_phase  = phase_chk && phase_err;
   assign ev_auto   = (st_q == ST_REQ) && cfg_valid;
   // ****************************************************************
   // Bus write path
   // ****************************************************************
   assign do_write  = aw_have_q && w_have_q && !bvalid;
   assign rd_take   = arvalid && arready;
   assign lane_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign auto_start = do_write && (awaddr_q == `EFC_OFS_CFG) && new_word[`EFC_CFG_AUTO] &&
                       is_serial && (st_q == ST_IDLE);
   always @* begin
      old_word = 32'h0000_0000;
      case (awaddr_q)
         `EFC_OFS_CFG: begin
            old_word[`EFC_CFG_TYPE]   = type_q;
            old_word[`EFC_CFG_SUPPLY] = supply_q;
            old_word[`EFC_CFG_TERM]   = term_q;
            old_word[`EFC_CFG_ERR]    = err_q;
            old_word[`EFC_CFG_AUTO]   = auto_q;
         end
         `EFC_OFS_LINES: old_word[15:0] = lines_q;
         `EFC_OFS_ABS: begin
            old_word[`EFC_ABS_TURNS] = turns_q;
            old_word[`EFC_ABS_RES]   = res_q;
         end
         `EFC_OFS_BAUD: old_word[11:0] = baud_q;
         `EFC_OFS_MASK: old_word[2:0]  = mask_q;
         default: old_word = 32'h0000_0000;
      endcase
      new_word = (old_word & ~lane_mask) | (wdata_q & lane_mask);
   end
   // ****************************************************************
   // Read mux
   // ****************************************************************
   always @* begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (araddr)
         `EFC_OFS_CFG: begin
            rd_word[`EFC_CFG_TYPE]   = type_q;
            rd_word[`EFC_CFG_SUPPLY] = supply_q;
            rd_word[`EFC_CFG_TERM]   = term_q;
            rd_word[`EFC_CFG_ERR]    = err_q;
            rd_word[`EFC_CFG_AUTO]   = auto_q;
         end
         `EFC_OFS_LINES: rd_word[15:0] = lines_q;
         `EFC_OFS_ABS: begin
            rd_word[`EFC_ABS_TURNS] = turns_q;
            rd_word[`EFC_ABS_RES]   = res_q;
         end
         `EFC_OFS_BAUD: rd_word[11:0] = baud_q;
         `EFC_OFS_STAT: rd_word[2:0]  = stat_q;
         `EFC_OFS_MASK: rd_word[2:0]  = mask_q;
         `EFC_OFS_INFO: rd_word[7:0]  = {baud_ok, phase_chk, wire_chk, is_serial_b, is_sincos,
                                         is_comm, is_pulse, cfg_req};
         default: rd_hit = 1'b0;
      endcase
   end

   // ****************************************************************
   // Baud decode
   // ****************************************************************
   always @* begin
      div_ok_d = is_serial_b;
      div_d    = 16'h0000;
      case (baud_q)
         `EFC_B100:  div_d = `EFC_DIV_100K;
         `EFC_B200:  div_d = `EFC_DIV_200K;
         `EFC_B300:  div_d = `EFC_DIV_300K;
         `EFC_B500:  div_d = `EFC_DIV_500K;
         `EFC_B1000: div_d = `EFC_DIV_1M;
         `EFC_B1500: div_d = `EFC_DIV_1M5;
         `EFC_B2000: div_d = `EFC_DIV_2M;
         default:    div_ok_d = 1'b0;
      endcase
   end
   // Set wins over the clear by read
   always @* begin
      stat_d = (rd_take && araddr == `EFC_OFS_STAT) ? 3'h0 : stat_q;
      stat_d[`EFC_ST_WIRE]  = stat_d[`EFC_ST_WIRE]  | ev_wire;
      stat_d[`EFC_ST_PHASE] = stat_d[`EFC_ST_PHASE] | ev_phase;
      stat_d[`EFC_ST_AUTO]  = stat_d[`EFC_ST_AUTO]  | ev_auto;
   end
   // ****************************************************************
   // AXI4-Lite handshakes
   // ****************************************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= `EFC_RESP_OKAY;
         arready   <= 1'b1;
         rvalid    <= 1'b0;
         rresp     <= `EFC_RESP_OKAY;
         rdata     <= 32'h0000_0000;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= 5'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            awready   <= 1'b0;
            awaddr_q  <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_q <= 1'b1;
            wready   <= 1'b0;
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid    <= 1'b1;
            bresp     <= (awaddr_q[1:0] != 2'h0 || awaddr_q > `EFC_OFS_MASK ||
                          awaddr_q == `EFC_OFS_STAT) ? `EFC_RESP_SLVERR : `EFC_RESP_OKAY;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
         if (rd_take) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_word;
            rresp   <= rd_hit ? `EFC_RESP_OKAY : `EFC_RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
   // ****************************************************************
   // Configuration registers and auto-configuration
   // ****************************************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         type_q   <= `EFC_RST_TYPE;
         supply_q <= `EFC_RST_SUPPLY;
         term_q   <= `EFC_RST_TERM;
         err_q    <= `EFC_RST_ERR;
         auto_q   <= 1'b0;
         lines_q  <= `EFC_RST_LINES;
         turns_q  <= 5'h00;
         res_q    <= 6'h00;
         baud_q   <= `EFC_RST_BAUD;
         mask_q   <= 3'h0;
         stat_q   <= 3'h0;
         st_q     <= ST_IDLE;
         cfg_req  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         if (do_write) begin
            case (awaddr_q)
               `EFC_OFS_CFG: begin
                  type_q   <= new_word[`EFC_CFG_TYPE];
                  supply_q <= new_word[`EFC_CFG_SUPPLY];
                  term_q   <= new_word[`EFC_CFG_TERM];
                  err_q    <= new_word[`EFC_CFG_ERR];
                  auto_q   <= new_word[`EFC_CFG_AUTO];
               end
               `EFC_OFS_LINES: lines_q <= new_word[15:0];
               `EFC_OFS_ABS: begin
                  turns_q <= new_word[`EFC_ABS_TURNS];
                  res_q   <= new_word[`EFC_ABS_RES];
               end
               `EFC_OFS_BAUD: baud_q <= new_word[11:0];
               `EFC_OFS_MASK: mask_q <= new_word[2:0];
               default: ;
            endcase
         end
         case (st_q)
            ST_IDLE: begin
               if (auto_start) begin
                  st_q    <= ST_REQ;
                  cfg_req <= 1'b1;
               end
            end
            ST_REQ: begin
               if (cfg_valid) begin
                  turns_q <= cfg_turns;
                  res_q   <= cfg_res;
                  if (is_sincos) begin
                     lines_q <= cfg_lines;
                  end
                  cfg_req <= 1'b0;
                  st_q    <= ST_DONE;
               end
            end
            ST_DONE: begin
               auto_q <= 1'b0;
               st_q   <= ST_IDLE;
            end
            default: begin
               cfg_req <= 1'b0;
               st_q    <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // Registered outputs to the encoder front end
   // ****************************************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         supply_sel     <= 3'h1;
         term_pulse_en  <= 1'b0;
         term_marker_en <= 1'b0;
         baud_div       <= 16'h0000;
         baud_ok        <= 1'b0;
         irq            <= 1'b0;
      end else begin
         case (supply_q)
            2'h0:    supply_sel <= 3'h1;
            2'h1:    supply_sel <= 3'h2;
            2'h2:    supply_sel <= 3'h4;
            default: supply_sel <= 3'h1;
         endcase
         term_pulse_en  <= (term_q == 2'h1) || (term_q == 2'h2);
         term_marker_en <= (term_q == 2'h2);
         baud_div       <= div_ok_d ? div_d : 16'h0000;
         baud_ok        <= div_ok_d;
         irq            <= |(stat_d & mask_q);
      end
   end

endmodule // efc_top
`default_nettype wire
